/* File: design/hpc_ack_drv.sv */
`timescale 1ns/100ps
// Drives the shared acknowledge pin and holds its driver on for a while
// after the pin is released high, so the line is pulled up actively before
// other bus clients may take it.
module hpc_ack_drv
  import hpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ack_req, // Level: acknowledge wanted this cycle.
  input wire logic [2:0] dly_code, // Output enable delay code.
  output logic host_ack_n, // Pin level, low means acknowledge.
  output logic host_ack_oe_n // Low while the pin is driven.
);

  hpc_ack_state_t state_reg; // Driver state.
  logic [1:0] cnt_reg; // Remaining hold cycles.
  logic [1:0] hold_cyc; // Hold time chosen by the code.

  assign hold_cyc = hpc_dly_cycles(dly_code);

  // Pin driver sequence: drive low, release high, then turn the driver off.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= HPC_ACK_IDLE;
      cnt_reg <= 2'h0;
      host_ack_n <= 1'b1;
      host_ack_oe_n <= 1'b1;
    end else begin
      case (state_reg)
        HPC_ACK_IDLE: begin
          // A request turns the driver on with the pin low.
          if (ack_req) begin
            state_reg <= HPC_ACK_DRIVE;
            host_ack_n <= 1'b0;
            host_ack_oe_n <= 1'b0;
          end
        end
        HPC_ACK_DRIVE: begin
          // Release the pin high; keep driving only if a hold is set.
          if (!ack_req) begin
            host_ack_n <= 1'b1;
            if (hold_cyc == 2'h0) begin
              state_reg <= HPC_ACK_IDLE;
              host_ack_oe_n <= 1'b1;
            end else begin
              state_reg <= HPC_ACK_HOLD;
              cnt_reg <= hold_cyc;
            end
          end
        end
        HPC_ACK_HOLD: begin
          // A fresh request during the hold pulls the pin low again.
          if (ack_req) begin
            state_reg <= HPC_ACK_DRIVE;
            host_ack_n <= 1'b0;
          end else if (cnt_reg == 2'h1) begin
            state_reg <= HPC_ACK_IDLE;
            host_ack_oe_n <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg - 2'h1;
          end
        end
        default: begin
          state_reg <= HPC_ACK_IDLE;
        end
      endcase
    end
  end

endmodule : hpc_ack_drv

/* File: design/hpc_pkg.sv */
package hpc_pkg;

  // Byte addresses of the two registers on the register port.
  localparam logic [7:0] HPC_CFG_OFS = 8'h10;
  localparam logic [7:0] HPC_IRQ_OFS = 8'h14;

  // Host port configuration fields and values after reset.
  localparam int HPC_DLY_LSB = 8;
  localparam int HPC_ORDER_BIT = 2;
  localparam int HPC_RWOE_BIT = 1;
  localparam int HPC_PRIO_BIT = 0;
  localparam logic [31:0] HPC_CFG_RST = 32'h0000_0104;
  localparam logic [31:0] HPC_CFG_WMASK = 32'h0000_0707;

  // System interrupt register: enables in the upper half, flags below.
  localparam logic [15:0] HPC_EN_RST = 16'h1000;
  localparam logic [15:0] HPC_EN_WMASK = 16'hDFFF;
  localparam int HPC_PIN_FLAG_LSB = 14;

  // Clock period and nominal acknowledge output enable delays, in nanoseconds.
  localparam int HPC_CLK_NS = 4;
  localparam int HPC_DLY3_NS = 2;
  localparam int HPC_DLY4_NS = 4;
  localparam int HPC_DLY5_NS = 6;
  localparam int HPC_DLY6_NS = 8;
  localparam int HPC_DLY7_NS = 10;

  // Delays as whole clock cycles, rounded up.
  localparam logic [1:0] HPC_DLY3_CYC = 2'((HPC_DLY3_NS + 3) / HPC_CLK_NS);
  localparam logic [1:0] HPC_DLY4_CYC = 2'((HPC_DLY4_NS + 3) / HPC_CLK_NS);
  localparam logic [1:0] HPC_DLY5_CYC = 2'((HPC_DLY5_NS + 3) / HPC_CLK_NS);
  localparam logic [1:0] HPC_DLY6_CYC = 2'((HPC_DLY6_NS + 3) / HPC_CLK_NS);
  localparam logic [1:0] HPC_DLY7_CYC = 2'((HPC_DLY7_NS + 3) / HPC_CLK_NS);

  // States of the acknowledge pin driver.
  typedef enum logic [1:0] {HPC_ACK_IDLE, HPC_ACK_DRIVE, HPC_ACK_HOLD}
    hpc_ack_state_t;

  // Turns a delay code into a hold time in cycles; low codes give none.
  function automatic logic [1:0] hpc_dly_cycles(input logic [2:0] code);
    case (code)
      3'h3: hpc_dly_cycles = HPC_DLY3_CYC;
      3'h4: hpc_dly_cycles = HPC_DLY4_CYC;
      3'h5: hpc_dly_cycles = HPC_DLY5_CYC;
      3'h6: hpc_dly_cycles = HPC_DLY6_CYC;
      3'h7: hpc_dly_cycles = HPC_DLY7_CYC;
      default: hpc_dly_cycles = 2'h0;
    endcase
  endfunction : hpc_dly_cycles

endpackage : hpc_pkg

/* File: design/hpc_regs.sv */
`timescale 1ns/100ps
// Contract
// - Delay code maps to 0..10 ns, default 001.
// - Delay keeps acknowledge driver on after release.
// - Order bit picks which half a halfword fills.
// - Option bit makes read/write pin the read enable.
// - Priority bit set lets internal client win ties.
// - Priority clear: host wins ties, no waits.
// - Reserved bits ignore writes and read zero.
// - Enabled set flags raise the interrupt.
// - Bits 31,30 enable pin flags, reset zero.
// - Host interface enable at 28 resets to one.
// - Bits 27,26 enable receive flags, reset zero.
// - Bits 25,24 enable transmit flags, reset zero.
// - Bits 23..20 enable buffer flags, reset zero.
// - Bits 19,18 enable fast port flags, reset zero.
// - Bits 17,16 enable link flags, reset zero.
// - Pin flag sets on change, cleared by host.
module hpc_regs
  import hpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_req, // Host access strobe, level.
  input wire logic host_wr, // Host access is a write.
  input wire logic [7:0] host_addr, // Host byte address.
  input wire logic [15:0] host_wdata, // Host halfword to write.
  input wire logic host_rw_pin, // Read/write pin, high means read.
  output logic host_gnt, // Host access taken this cycle.
  output logic [15:0] host_rdata, // Host halfword read back.
  output logic host_ack_n, // Acknowledge pin level.
  output logic host_ack_oe_n, // Acknowledge pin driver enable.
  output logic host_data_oe_n, // Host data bus driver enable.
  input wire logic loc_req, // Internal client access strobe.
  input wire logic loc_wr, // Internal client access is a write.
  input wire logic [7:0] loc_addr, // Internal client byte address.
  input wire logic [31:0] loc_wdata, // Internal client write word.
  output logic loc_gnt, // Internal access taken this cycle.
  output logic [31:0] loc_rdata, // Internal client read word.
  input wire logic [1:0] pin_irq_src, // Selected pins for pin flags.
  input wire logic [1:0] pin_irq_clr, // Pulses: host cleared status.
  input wire logic [12:0] src_irq_flags, // Summary flags of other blocks.
  output logic irq // Interrupt output, active high.
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage and decode

  logic [31:0] cfg_reg; // Host port configuration word.
  logic [15:0] en_reg; // Interrupt enables, bits 31..16 of the word.
  logic [1:0] pin_flag_reg; // Sticky pin change flags.
  logic [1:0] pin_prev_reg; // Pin levels of the previous cycle.
  logic [15:0] flags; // Flag half of the interrupt word.
  logic [31:0] sys_word; // Whole interrupt word as read.
  logic same_reg_tie; // Both parties hit one register together.
  logic host_upper; // Host halfword goes to the upper half.
  logic [31:0] host_mask; // Lanes the host write touches.
  logic [31:0] host_word; // Host halfword placed on both halves.
  logic host_we_cfg, host_we_sys, loc_we_cfg, loc_we_sys;
  logic [31:0] cfg_next; // Next configuration word.
  logic [15:0] en_next; // Next enables.

  // Places one write into a word under a lane mask.
  function automatic logic [31:0] hpc_merge(input logic [31:0] old,
                                            input logic [31:0] data,
                                            input logic [31:0] mask);
    hpc_merge = (old & ~mask) | (data & mask);
  endfunction : hpc_merge

  // Word address match, ignoring the byte lanes.
  function automatic logic hpc_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    hpc_hit = (addr[7:2] == ofs[7:2]);
  endfunction : hpc_hit

  // Reads a register word at an address; unmapped words read zero.
  function automatic logic [31:0] hpc_read(input logic [7:0] addr,
                                           input logic [31:0] cfg,
                                           input logic [31:0] sys);
    if (hpc_hit(addr, HPC_CFG_OFS)) begin
      hpc_read = cfg;
    end else if (hpc_hit(addr, HPC_IRQ_OFS)) begin
      hpc_read = sys;
    end else begin
      hpc_read = 32'h0000_0000;
    end
  endfunction : hpc_read

  assign flags = {pin_flag_reg, 1'b0, src_irq_flags};
  assign sys_word = {en_reg, flags};

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration between host and internal client

  // A tie is two accesses to the same register in the same cycle.
  assign same_reg_tie = host_req && loc_req &&
                        (host_addr[7:2] == loc_addr[7:2]);

  // With priority set the host waits on a tie; else it never waits.
  assign host_gnt = host_req &&
                    !(same_reg_tie && cfg_reg[HPC_PRIO_BIT]);
  assign loc_gnt = loc_req && !(same_reg_tie && !cfg_reg[HPC_PRIO_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  // Host halfword placement

  // Address bit 1 picks the half, turned round when big endian is set.
  assign host_upper = host_addr[1] ^ cfg_reg[HPC_ORDER_BIT];
  assign host_mask = host_upper ? 32'hFFFF_0000 : 32'h0000_FFFF;
  assign host_word = {host_wdata, host_wdata};

  assign host_we_cfg = host_gnt && host_wr && hpc_hit(host_addr, HPC_CFG_OFS);
  assign host_we_sys = host_gnt && host_wr &&
                       hpc_hit(host_addr, HPC_IRQ_OFS);
  assign loc_we_cfg = loc_gnt && loc_wr && hpc_hit(loc_addr, HPC_CFG_OFS);
  assign loc_we_sys = loc_gnt && loc_wr && hpc_hit(loc_addr, HPC_IRQ_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  // Next values; only one party can be granted a given register per cycle.
  always_comb begin
    cfg_next = cfg_reg;
    en_next = en_reg;
    if (host_we_cfg) begin
      cfg_next = hpc_merge(cfg_reg, host_word,
                           host_mask & HPC_CFG_WMASK);
    end else if (loc_we_cfg) begin
      cfg_next = hpc_merge(cfg_reg, loc_wdata, HPC_CFG_WMASK);
    end
    if (host_we_sys && host_upper) begin
      en_next = (en_reg & ~HPC_EN_WMASK) | (host_wdata & HPC_EN_WMASK);
    end else if (loc_we_sys) begin
      en_next = (en_reg & ~HPC_EN_WMASK) | (loc_wdata[31:16] & HPC_EN_WMASK);
    end
  end

  // Configuration register; reserved bits stay zero.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_reg <= HPC_CFG_RST;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Interrupt enables; only the host interface enable comes up set.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      en_reg <= HPC_EN_RST;
    end else begin
      en_reg <= en_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin change flags

  // Any level change sets a flag; a clear in the same cycle loses.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_prev_reg <= 2'h0;
      pin_flag_reg <= 2'h0;
    end else begin
      pin_prev_reg <= pin_irq_src;
      pin_flag_reg <= (pin_irq_src ^ pin_prev_reg) |
                      (pin_flag_reg & ~pin_irq_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output

  // Each flag is a source only while its enable is set.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  // Host read picks the half chosen by the endianness setting.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      host_rdata <= 16'h0000;
    end else if (host_gnt && !host_wr) begin
      if (host_upper) begin
        host_rdata <= 16'(hpc_read(host_addr, cfg_reg, sys_word) >> 16);
      end else begin
        host_rdata <= 16'(hpc_read(host_addr, cfg_reg, sys_word));
      end
    end
  end

  // Internal client reads the whole word.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      loc_rdata <= 32'h0000_0000;
    end else if (loc_gnt && !loc_wr) begin
      loc_rdata <= hpc_read(loc_addr, cfg_reg, sys_word);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host pins

  // With the option set the host strobe and read/write pin gate the data driver, not the grant.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      host_data_oe_n <= 1'b1;
    end else if (cfg_reg[HPC_RWOE_BIT]) begin
      host_data_oe_n <= !(host_req && host_rw_pin);
    end else begin
      host_data_oe_n <= !(host_gnt && !host_wr);
    end
  end

  // Acknowledge pin driver with programmable hold of its enable.
  hpc_ack_drv u_ack (
    .clk(clk),
    .nrst(nrst),
    .ack_req(host_gnt),
    .dly_code(cfg_reg[HPC_DLY_LSB +: 3]),
    .host_ack_n(host_ack_n),
    .host_ack_oe_n(host_ack_oe_n)
  );

endmodule : hpc_regs

/* File: tb/hpc_host_model.sv */
`timescale 1ns/100ps
// Microcontroller on the host bus; holds each request until granted.
module hpc_host_model (
  input wire logic clk,
  input wire logic host_gnt,
  input wire logic [15:0] host_rdata,
  output logic host_req,
  output logic host_wr,
  output logic [7:0] host_addr,
  output logic [15:0] host_wdata,
  output logic host_rw_pin
);
  initial begin
    host_req = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'h00;
    host_wdata = 16'h0000;
    host_rw_pin = 1'b1;
  end
  // One access; the read/write pin is high for reads. Address and data invert on release.
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [15:0] wd, output logic [15:0] rd, output int w);
    @(posedge clk);
    host_req <= 1'b1;
    host_wr <= wr;
    host_addr <= a;
    host_wdata <= wd;
    host_rw_pin <= !wr;
    w = 0;
    @(posedge clk);
    while (host_gnt !== 1'b1 && w < 20) begin
      w++;
      @(posedge clk);
    end
    host_req <= 1'b0;
    host_addr <= ~a;
    host_wdata <= ~wd;
    @(negedge clk);
    rd = host_rdata;
  endtask : xfer
endmodule : hpc_host_model

/* File: tb/hpc_regs_bench.sv */
`timescale 1ns/100ps
module hpc_regs_bench;
  import hpc_pkg::*;
  logic clk = 0, nrst = 0, loc_req = 0, loc_wr = 0, irq;
  logic [7:0] loc_addr = 8'h00, host_addr;
  logic [31:0] loc_wdata = 32'h0000_0000, loc_rdata, rd;
  logic [1:0] pin_irq_src = 2'h0, pin_irq_clr = 2'h0;
  logic [12:0] src_irq_flags = 13'h0000;
  logic host_req, host_wr, host_rw_pin, host_gnt, loc_gnt;
  logic host_ack_n, host_ack_oe_n, host_data_oe_n;
  logic [15:0] host_wdata, host_rdata, hr;
  int error_cnt = 0, checks = 0, hw, lw, n;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd;} hpc_row_t;
  // Write then read back: reserved bits drop, unmapped reads zero.
  hpc_row_t rows[5] = '{'{8'h10, 32'hFFFF_FFFF, 32'h0000_0707},
    '{8'h10, 32'h0000_0000, 32'h0000_0000},
    '{8'h14, 32'hFFFF_FFFF, 32'hDFFF_0000},
    '{8'h14, 32'h0000_0000, 32'h0000_0000},
    '{8'h20, 32'hFFFF_FFFF, 32'h0000_0000}};
  always #2 clk = ~clk;
  hpc_regs i_dut (.clk, .nrst, .host_req, .host_wr, .host_addr, .host_wdata,
    .host_rw_pin, .host_gnt, .host_rdata, .host_ack_n, .host_ack_oe_n,
    .host_data_oe_n, .loc_req, .loc_wr, .loc_addr, .loc_wdata, .loc_gnt,
    .loc_rdata, .pin_irq_src, .pin_irq_clr, .src_irq_flags, .irq);
  hpc_host_model i_host (.clk, .host_gnt, .host_rdata, .host_req, .host_wr,
    .host_addr, .host_wdata, .host_rw_pin);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // Internal client access, held until granted.
  task automatic lx(input logic wr, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] r, output int w);
    @(posedge clk);
    loc_req <= 1'b1;
    loc_wr <= wr;
    loc_addr <= a;
    loc_wdata <= wd;
    w = 0;
    @(posedge clk);
    while (loc_gnt !== 1'b1 && w < 20) begin
      w++;
      @(posedge clk);
    end
    loc_req <= 1'b0;
    @(negedge clk);
    r = loc_rdata;
  endtask : lx
  // The tests need about 250 cycles; allow 6000, about 24 times that.
  initial begin
    #24000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    lx(0, 8'h10, 0, rd, lw);
    check(rd, 32'h0000_0104);
    lx(0, 8'h14, 0, rd, lw);
    check(rd, 32'h1000_0000);
    $display("reset values done");
    foreach (rows[i]) begin
      lx(1, rows[i].a, rows[i].wd, rd, lw);
      lx(0, rows[i].a, 0, rd, lw);
      check(rd, rows[i].rd);
    end
    i_host.xfer(1, 8'h16, 16'hABCD, hr, hw);
    lx(0, 8'h14, 0, rd, lw);
    check(rd, 32'h8BCD_0000);
    lx(1, 8'h10, 32'h0000_0004, rd, lw);
    i_host.xfer(1, 8'h14, 16'h1234, hr, hw);
    i_host.xfer(1, 8'h16, 16'hFFFF, hr, hw);
    i_host.xfer(0, 8'h14, 0, hr, hw);
    check(hr, 16'h1234);
    $display("rows and byte order done");
    for (int i = 0; i < 13; i++) begin
      lx(1, 8'h14, 32'h0001_0000 << i, rd, lw);
      @(posedge clk) src_irq_flags <= ~(13'h0001 << i);
      repeat (3) @(negedge clk);
      check(irq, 0);
      @(posedge clk) src_irq_flags <= 13'h0001 << i;
      repeat (3) @(negedge clk);
      check(irq, 1);
    end
    src_irq_flags <= 13'h0000;
    lx(1, 8'h14, 32'h4000_0000, rd, lw);
    @(posedge clk) pin_irq_src <= 2'h1;
    repeat (3) @(negedge clk);
    check(irq, 1);
    lx(0, 8'h14, 0, rd, lw);
    check(rd, 32'h4000_4000);
    @(posedge clk) pin_irq_clr <= 2'h1;
    @(posedge clk) pin_irq_clr <= 2'h0;
    repeat (2) @(negedge clk);
    check(irq, 0);
    $display("interrupts done");
    // Hold after release is the nominal delay rounded up to 4 ns cycles.
    for (int c = 0; c < 8; c++) begin
      lx(1, 8'h10, 32'h0000_0004 | (c << 8), rd, lw);
      i_host.xfer(0, 8'h10, 0, hr, hw);
      for (n = 0; host_ack_n !== 1'b1 && n < 5; n++) @(negedge clk);
      for (n = 0; host_ack_oe_n === 1'b0 && n < 8; n++) @(negedge clk);
      check(n, (c < 3) ? 0 : ((c - 2) * 2 + 3) / 4);
    end
    $display("ack delay done");
    lx(1, 8'h10, 32'h0000_0006, rd, lw);
    i_host.xfer(0, 8'h14, 0, hr, hw);
    check(host_data_oe_n, 0);
    i_host.xfer(1, 8'h14, 16'h1000, hr, hw);
    check(host_data_oe_n, 1);
    fork
      i_host.xfer(0, 8'h14, 0, hr, hw);
      lx(0, 8'h14, 0, rd, lw);
    join
    check(hw, 0);
    check(lw, 1);
    lx(1, 8'h10, 32'h0000_0007, rd, lw);
    // The losing host read still gets its data enable from the strobe and pin.
    fork
      i_host.xfer(0, 8'h14, 0, hr, hw);
      lx(0, 8'h14, 0, rd, lw);
      begin
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(host_data_oe_n, 0);
      end
    join
    check(lw, 0);
    check(hw, 1);
    $display("priority and data enable done");
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    lx(0, 8'h10, 0, rd, lw);
    check(rd, 32'h0000_0104);
    $display("second reset done");
    stop_test();
  end
endmodule : hpc_regs_bench
bind hpc_regs hpc_sva i_sva (.clk, .nrst, .host_req, .host_wr, .host_addr,
  .host_rw_pin, .host_gnt, .host_ack_n, .host_ack_oe_n, .host_data_oe_n,
  .loc_req, .loc_addr, .loc_gnt);

/* File: tb/hpc_sva.sv */
`timescale 1ns/100ps
// Timing checks on the grant, acknowledge and data enable ports.
module hpc_sva (
  input wire logic clk,
  input wire logic nrst,
  input wire logic host_req,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic host_rw_pin,
  input wire logic host_gnt,
  input wire logic host_ack_n,
  input wire logic host_ack_oe_n,
  input wire logic host_data_oe_n,
  input wire logic loc_req,
  input wire logic [7:0] loc_addr,
  input wire logic loc_gnt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic same_word; // Both parties aim at one register word.
  assign same_word = host_addr[7:2] == loc_addr[7:2];
  // Pin released and left idle long enough for the longest hold.
  sequence rel_quiet_s;
    $rose(host_ack_n) ##0 !host_gnt [*4];
  endsequence
  host_no_wait_a: assert property (
    host_req && !(loc_req && same_word) |-> host_gnt)
    else $error("host stalled");
  loc_no_tie_a: assert property (
    loc_req && !(host_req && same_word) |-> loc_gnt)
    else $error("local stalled");
  one_winner_a: assert property (
    !(host_gnt && loc_gnt && same_word))
    else $error("both won");
  ack_drive_a: assert property (
    host_gnt |=> !host_ack_n && !host_ack_oe_n)
    else $error("no ack");
  ack_release_a: assert property (
    !host_gnt |=> host_ack_n)
    else $error("ack held");
  ack_oe_cover_a: assert property (
    !host_ack_n |-> !host_ack_oe_n)
    else $error("ack undriven");
  oe_hold_bound_a: assert property (
    rel_quiet_s |-> host_ack_oe_n)
    else $error("oe hold long");
  read_oe_on_a: assert property (
    host_gnt && !host_wr && host_rw_pin |=> !host_data_oe_n)
    else $error("data oe off");
  idle_oe_off_a: assert property (
    !host_req |=> host_data_oe_n)
    else $error("data oe on");
endmodule : hpc_sva
